//--- gpib_cfg.svh
// Offsets, field positions, reset values and timing of the IEEE 488 device interface
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_CTRL    8'h00
`define OFS_STATUS  8'h04
`define OFS_TXDATA  8'h08
`define OFS_RXDATA  8'h0C
`define OFS_STB     8'h10
`define OFS_EVENT   8'h14

// ==========================================================================
// Fields and reset values
`define ADDR_MAX    5'h1E
`define ADDR_RST    5'h01
`define ADDR_NONE   5'h1F
`define STB_RSV_BIT 6
`define STB_RST     8'h00
`define EV_DCLR     0
`define EV_IFC      1
`define EV_MODE     2

// ==========================================================================
// Bus command codes (low seven bits)
`define CMD_GTL     7'h01
`define CMD_SDC     7'h04
`define CMD_LLO     7'h11
`define CMD_DCL     7'h14
`define CMD_SPE     7'h18
`define CMD_SPD     7'h19
`define GRP_LISTEN  2'h1
`define GRP_TALK    2'h2

// ==========================================================================
// Timing
`define CLK_MHZ     200
`define SETTLE_NS   2000
`define SETTLE_CYC  ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- gpib_controller_model.sv
// Behavioural bus controller that commands the device and reads its bytes
`timescale 1ns/1ps
module gpib_controller_model (
  input  wire logic       hclk,
  input  wire logic [7:0] w_dio,
  input  wire logic       w_dav,
  input  wire logic       w_nrfd,
  input  wire logic       w_ndac,
  input  wire logic       w_eoi,
  output logic      [7:0] c_dio,
  output logic            c_dav,
  output logic            c_nrfd,
  output logic            c_ndac,
  output logic            atn_n,
  output logic            ren_n
);
  int slow = 0;
  initial begin
    {c_dio, c_dav, c_nrfd, c_ndac} = '0;
    {atn_n, ren_n} = 2'b11;
  end
  // ==========================================================================
  // Source side: command byte under attention, data byte without
  task automatic send(input logic [7:0] b, input logic atn);
    atn_n <= !atn;
    c_dio <= b;
    repeat (3) @(posedge hclk);
    while (!w_nrfd) @(posedge hclk);
    c_dav <= 1'b1;
    do @(posedge hclk); while (!w_ndac);
    c_dav <= 1'b0;
    c_dio <= 8'h00;
    repeat (4) @(posedge hclk);
  endtask : send
  // ==========================================================================
  // Acceptor side, with an optional slow accept
  task automatic take(output logic [7:0] b, output logic e);
    atn_n <= 1'b1;
    c_ndac <= 1'b1;
    do @(posedge hclk); while (w_dav);
    b = ~w_dio;
    e = !w_eoi;
    c_nrfd <= 1'b1;
    repeat (slow) @(posedge hclk);
    c_ndac <= 1'b0;
    do @(posedge hclk); while (!w_dav);
    c_nrfd <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : take
endmodule : gpib_controller_model

//--- gpib_pkg.sv
// Types of the IEEE 488 device interface
package gpib_pkg;
  typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_OFFER} sh_state_t;
  typedef enum logic {AH_READY, AH_TAKEN} ah_state_t;
  typedef enum logic [1:0] {RL_LOCAL, RL_REMOTE, RL_LOCAL_LOCK, RL_REMOTE_LOCK} rl_state_t;
endpackage : gpib_pkg

//--- ieee488_device_interface.sv
// IEEE 488 device-side interface with AHB-Lite register access
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module ieee488_device_interface
  import gpib_pkg::*;
#(
  parameter int PANEL_W    = 8,
  parameter int SETTLE_CYC = `SETTLE_CYC
)(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [7:0]         dio_in,
  output logic      [7:0]         dio_out,
  output logic      [7:0]         dio_oe_n,
  input  wire logic               dav_in,
  output logic                    dav_out,
  output logic                    dav_oe_n,
  input  wire logic               nrfd_in,
  output logic                    nrfd_out,
  output logic                    nrfd_oe_n,
  input  wire logic               ndac_in,
  output logic                    ndac_out,
  output logic                    ndac_oe_n,
  input  wire logic               eoi_in,
  output logic                    eoi_out,
  output logic                    eoi_oe_n,
  input  wire logic               atn_in,
  input  wire logic               ifc_in,
  input  wire logic               ren_in,
  output logic                    srq_out,
  output logic                    srq_oe_n,
  input  wire logic               rtl_key_in,
  input  wire logic [PANEL_W-1:0] panel_in,
  output logic      [PANEL_W-1:0] panel_out,
  output logic                    remote_led,
  output logic                    dev_clear
);

  localparam int              NS       = 16 + PANEL_W;
  localparam int              CW       = $clog2(SETTLE_CYC + 1);
  localparam logic [NS-1:0]   SYNC_RST = {{15{1'b1}}, {(PANEL_W + 1){1'b0}}};
  localparam logic [CW-1:0]   SET_LD   = CW'(SETTLE_CYC - 1);

  // ========================================================================
  // Pin synchronisers
  logic [NS-1:0]      sync_a;
  logic [NS-1:0]      sync_b;
  logic [6:0]         ctl_n;
  logic [7:0]         bus_n;
  logic               rtl_key;
  logic [PANEL_W-1:0] panel_s;
  logic               atn;
  logic               ifc;
  logic               ren;
  logic               dav;
  logic               nrfd;
  logic               ndac;
  logic               eoi;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      sync_a <= {atn_in, ifc_in, ren_in, dav_in, nrfd_in, ndac_in, eoi_in,
                 dio_in, rtl_key_in, panel_in};
      sync_b <= sync_a;
    end
  end

  assign {ctl_n, bus_n, rtl_key, panel_s} = sync_b;
  assign atn  = ~ctl_n[6];
  assign ifc  = ~ctl_n[5];
  assign ren  = ~ctl_n[4];
  assign dav  = ~ctl_n[3];
  assign nrfd = ~ctl_n[2];
  assign ndac = ~ctl_n[1];
  assign eoi  = ~ctl_n[0];

  // ========================================================================
  // Remote/local controller
  rl_if rl ();
  logic mla_evt;
  logic gtl_evt;
  logic llo_evt;

  assign rl.ren_on  = ren;
  assign rl.mla_evt = mla_evt;
  assign rl.gtl_evt = gtl_evt;
  assign rl.llo_evt = llo_evt;
  assign rl.rtl_key = rtl_key;

  remote_local u_rl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rl      (rl.ctl)
  );

  // ========================================================================
  // State
  logic [4:0]         addr,      next_addr;
  logic [7:0]         stb,       next_stb;
  logic [7:0]         tx_byte,   next_tx_byte;
  logic               tx_eoi,    next_tx_eoi;
  logic               tx_valid,  next_tx_valid;
  logic [7:0]         rx_byte,   next_rx_byte;
  logic               rx_eoi,    next_rx_eoi;
  logic               rx_valid,  next_rx_valid;
  logic               talk,      next_talk;
  logic               listen,    next_listen;
  logic               spoll,     next_spoll;
  logic               stb_sent,  next_stb_sent;
  sh_state_t          sh,        next_sh;
  ah_state_t          ah,        next_ah;
  logic [CW-1:0]      cnt,       next_cnt;
  logic [7:0]         out_byte,  next_out_byte;
  logic               out_eoi,   next_out_eoi;
  logic [2:0]         events,    next_events;
  logic               ph_valid,  next_ph_valid;
  logic               ph_write,  next_ph_write;
  logic [7:0]         ph_addr,   next_ph_addr;
  logic [31:0]        next_hrdata;
  logic [7:0]         next_dio_oe_n;
  logic               next_dav_oe_n;
  logic               next_nrfd_oe_n;
  logic               next_ndac_oe_n;
  logic               next_eoi_oe_n;
  logic               next_srq_oe_n;
  logic [PANEL_W-1:0] next_panel_out;
  logic               next_remote_led;
  logic               next_dev_clear;
  logic               low_q;
  logic               acc;
  logic               take;
  logic               clr;
  logic               src_go;
  logic               ah_active;
  logic               ah_ready;
  logic [6:0]         cmd;
  logic [2:0]         ev_set;
  logic [2:0]         ev_clr;

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_addr     = addr;
    next_stb      = stb;
    next_tx_byte  = tx_byte;
    next_tx_eoi   = tx_eoi;
    next_tx_valid = tx_valid;
    next_rx_byte  = rx_byte;
    next_rx_eoi   = rx_eoi;
    next_rx_valid = rx_valid;
    next_talk     = talk;
    next_listen   = listen;
    next_spoll    = spoll;
    next_stb_sent = atn ? 1'b0 : stb_sent;
    next_sh       = sh;
    next_ah       = ah;
    next_cnt      = cnt;
    next_out_byte = out_byte;
    next_out_eoi  = out_eoi;
    next_hrdata   = 32'h0000_0000;
    mla_evt       = 1'b0;
    gtl_evt       = 1'b0;
    llo_evt       = 1'b0;
    take          = 1'b0;
    clr           = 1'b0;
    ev_set        = 3'h0;
    ev_clr        = 3'h0;
    cmd           = bus_n[6:0] ^ 7'h7F;

    // Acceptor handshake: always ready for commands, data only if room
    ah_active = atn | listen;
    ah_ready  = atn | ~rx_valid;
    case (ah)
      AH_READY: begin
        if (ah_active && ah_ready && dav) begin
          take    = 1'b1;
          next_ah = AH_TAKEN;
        end
      end
      AH_TAKEN: begin
        if (!dav) begin
          next_ah = AH_READY;
        end
      end
      default: next_ah = AH_READY;
    endcase

    if (take && atn) begin
      if (cmd[6:5] == `GRP_LISTEN) begin
        if (cmd[4:0] == addr) begin
          next_listen = 1'b1;
          next_talk   = 1'b0;
          mla_evt     = 1'b1;
        end else if (cmd[4:0] == `ADDR_NONE) begin
          next_listen = 1'b0;
        end
      end else if (cmd[6:5] == `GRP_TALK) begin
        if (cmd[4:0] == addr) begin
          next_talk   = 1'b1;
          next_listen = 1'b0;
        end else begin
          next_talk   = 1'b0;
        end
      end else begin
        case (cmd)
          `CMD_GTL: gtl_evt = listen;
          `CMD_SDC: clr = listen;
          `CMD_DCL: clr = 1'b1;
          `CMD_LLO: llo_evt = 1'b1;
          `CMD_SPE: next_spoll = 1'b1;
          `CMD_SPD: next_spoll = 1'b0;
          // Trigger, poll configure and take control fall through
          default: ;
        endcase
      end
    end

    if (take && !atn) begin
      next_rx_byte  = ~bus_n;
      next_rx_eoi   = eoi;
      next_rx_valid = 1'b1;
    end

    // Source handshake
    src_go = talk & ~atn & ~ifc & (spoll ? ~stb_sent : tx_valid);
    case (sh)
      SH_IDLE: begin
        if (src_go) begin
          next_out_byte = spoll ? stb : tx_byte;
          next_out_eoi  = ~spoll & tx_eoi;
          next_cnt      = SET_LD;
          next_sh       = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        if (!src_go) begin
          next_sh = SH_IDLE;
        end else if (cnt != '0) begin
          next_cnt = cnt - CW'(1);
        end else if (!nrfd) begin
          next_sh = SH_OFFER;
        end
      end
      SH_OFFER: begin
        if (atn || ifc) begin
          next_sh = SH_IDLE;
        end else if (!ndac) begin
          next_sh = SH_IDLE;
          if (spoll) begin
            next_stb_sent = 1'b1;
            next_stb[`STB_RSV_BIT] = 1'b0;
          end else begin
            next_tx_valid = 1'b0;
          end
        end
      end
      default: next_sh = SH_IDLE;
    endcase

    if (ifc) begin
      next_talk   = 1'b0;
      next_listen = 1'b0;
      next_spoll  = 1'b0;
      ev_set[`EV_IFC] = 1'b1;
    end

    if (clr) begin
      next_rx_valid = 1'b0;
      next_tx_valid = 1'b0;
      ev_set[`EV_DCLR] = 1'b1;
    end

    if (rl.remote != remote_led) begin
      ev_set[`EV_MODE] = 1'b1;
    end

    // AHB-Lite address phase
    acc           = hsel & hready & htrans[1];
    next_ph_valid = acc;
    next_ph_write = hwrite;
    next_ph_addr  = haddr[7:0];
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `OFS_CTRL:   next_hrdata = {27'h0, addr};
        `OFS_STATUS: next_hrdata = {23'h0, ren, stb[`STB_RSV_BIT], rx_valid, tx_valid,
                                    spoll, listen, talk, 1'b0, rl.remote};
        `OFS_RXDATA: begin
          next_hrdata   = {22'h0, rx_valid, rx_eoi, rx_byte};
          // Pop only a held byte, so a byte taken in this cycle is kept
          if (rx_valid) begin
            next_rx_valid = 1'b0;
          end
        end
        `OFS_STB:    next_hrdata = {24'h0, stb};
        `OFS_EVENT:  next_hrdata = {29'h0, events};
        default:     next_hrdata = 32'h0000_0000;
      endcase
    end

    // AHB-Lite data phase writes
    if (ph_valid && ph_write) begin
      case (ph_addr)
        `OFS_CTRL: begin
          if (hwdata[4:0] <= `ADDR_MAX) begin
            next_addr = hwdata[4:0];
          end
        end
        `OFS_TXDATA: begin
          if (!tx_valid) begin
            next_tx_byte  = hwdata[7:0];
            next_tx_eoi   = hwdata[8];
            next_tx_valid = 1'b1;
          end
        end
        `OFS_STB:   next_stb = hwdata[7:0];
        `OFS_EVENT: ev_clr = hwdata[2:0];
        default: ;
      endcase
    end

    // Set wins over clear
    next_events = (events & ~ev_clr) | ev_set;

    // Pin drive: data only while attention is released, so no parallel poll reply
    next_dio_oe_n   = (next_sh != SH_IDLE) ? ~next_out_byte : 8'hFF;
    next_dav_oe_n   = ~(next_sh == SH_OFFER);
    next_eoi_oe_n   = ~((next_sh != SH_IDLE) & next_out_eoi);
    next_nrfd_oe_n  = ~((next_ah == AH_TAKEN) | (ah_active & ~ah_ready));
    next_ndac_oe_n  = ~(ah_active & (next_ah == AH_READY));
    next_srq_oe_n   = ~next_stb[`STB_RSV_BIT];
    next_remote_led = rl.remote;
    // Panel path only gated; stored settings are never touched here
    next_panel_out  = rl.remote ? '0 : panel_s;
    next_dev_clear  = clr;
  end

  // ========================================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr       <= `ADDR_RST;
      stb        <= `STB_RST;
      tx_byte    <= 8'h00;
      tx_eoi     <= 1'b0;
      tx_valid   <= 1'b0;
      rx_byte    <= 8'h00;
      rx_eoi     <= 1'b0;
      rx_valid   <= 1'b0;
      talk       <= 1'b0;
      listen     <= 1'b0;
      spoll      <= 1'b0;
      stb_sent   <= 1'b0;
      sh         <= SH_IDLE;
      ah         <= AH_READY;
      cnt        <= '0;
      out_byte   <= 8'h00;
      out_eoi    <= 1'b0;
      events     <= 3'h0;
      ph_valid   <= 1'b0;
      ph_write   <= 1'b0;
      ph_addr    <= 8'h00;
      hrdata     <= 32'h0000_0000;
      dio_oe_n   <= 8'hFF;
      dav_oe_n   <= 1'b1;
      nrfd_oe_n  <= 1'b1;
      ndac_oe_n  <= 1'b1;
      eoi_oe_n   <= 1'b1;
      srq_oe_n   <= 1'b1;
      panel_out  <= '0;
      remote_led <= 1'b0;
      dev_clear  <= 1'b0;
      low_q      <= 1'b0;
      hreadyout  <= 1'b1;
    end else begin
      addr       <= next_addr;
      stb        <= next_stb;
      tx_byte    <= next_tx_byte;
      tx_eoi     <= next_tx_eoi;
      tx_valid   <= next_tx_valid;
      rx_byte    <= next_rx_byte;
      rx_eoi     <= next_rx_eoi;
      rx_valid   <= next_rx_valid;
      talk       <= next_talk;
      listen     <= next_listen;
      spoll      <= next_spoll;
      stb_sent   <= next_stb_sent;
      sh         <= next_sh;
      ah         <= next_ah;
      cnt        <= next_cnt;
      out_byte   <= next_out_byte;
      out_eoi    <= next_out_eoi;
      events     <= next_events;
      ph_valid   <= next_ph_valid;
      ph_write   <= next_ph_write;
      ph_addr    <= next_ph_addr;
      hrdata     <= next_hrdata;
      dio_oe_n   <= next_dio_oe_n;
      dav_oe_n   <= next_dav_oe_n;
      nrfd_oe_n  <= next_nrfd_oe_n;
      ndac_oe_n  <= next_ndac_oe_n;
      eoi_oe_n   <= next_eoi_oe_n;
      srq_oe_n   <= next_srq_oe_n;
      panel_out  <= next_panel_out;
      remote_led <= next_remote_led;
      dev_clear  <= next_dev_clear;
      low_q      <= 1'b0;
      hreadyout  <= 1'b1;
    end
  end

  // Open-collector lines only ever pull low; ATN, IFC and REN are never driven
  assign dio_out  = {8{low_q}};
  assign dav_out  = low_q;
  assign nrfd_out = low_q;
  assign ndac_out = low_q;
  assign eoi_out  = low_q;
  assign srq_out  = low_q;
  assign hresp    = low_q;

endmodule : ieee488_device_interface

//--- ieee488_device_interface_asserts.sv
// Concurrent checks on the ports of the device interface
`timescale 1ns/1ps
module ieee488_device_interface_asserts #(
  parameter int PANEL_W = 8
)(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               atn_in,
  input wire logic               ren_in,
  input wire logic               dav_in,
  input wire logic               ndac_in,
  input wire logic [7:0]         dio_oe_n,
  input wire logic               dav_oe_n,
  input wire logic               nrfd_oe_n,
  input wire logic               ndac_oe_n,
  input wire logic               eoi_oe_n,
  input wire logic [PANEL_W-1:0] panel_in,
  input wire logic [PANEL_W-1:0] panel_out,
  input wire logic               remote_led,
  input wire logic               dev_clear
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Assertions
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_no_ppoll: assert property ((!atn_in)[*6] |-> dio_oe_n == 8'hFF)
    else $error("data lines pulled under attention");
  a_no_ctl_eoi: assert property ((!atn_in)[*6] |-> eoi_oe_n)
    else $error("end line pulled under attention");
  a_panel_block: assert property (remote_led[*2] |-> panel_out == '0)
    else $error("panel passed in remote");
  a_panel_pass: assert property ((!remote_led)[*4] |-> panel_out == $past(panel_in, 3))
    else $error("panel not passed in local");
  a_ren_local: assert property (ren_in[*6] |-> !remote_led)
    else $error("remote without remote enable");
  a_clear_pulse: assert property (dev_clear |=> !dev_clear)
    else $error("clear pulse too long");
  a_data_hold: assert property (!dav_oe_n |-> $stable(dio_oe_n))
    else $error("data moved while valid");
  a_dav_release: assert property (!dav_oe_n && ndac_in |-> ##[1:6] dav_oe_n)
    else $error("valid not released after accept");
  a_ndac_order: assert property ($rose(ndac_oe_n) && !dav_in && dav_oe_n |-> !nrfd_oe_n)
    else $error("accept before not-ready");
  // ==========================================================================
  // Covers
  c_remote: cover property ($rose(remote_led));
  c_clear: cover property (dev_clear);
  c_send: cover property ($fell(dav_oe_n));
endmodule : ieee488_device_interface_asserts

bind ieee488_device_interface ieee488_device_interface_asserts #(.PANEL_W(PANEL_W)) chk (
  .hclk, .hresetn, .hreadyout, .hresp, .atn_in, .ren_in, .dav_in, .ndac_in, .dio_oe_n,
  .dav_oe_n, .nrfd_oe_n, .ndac_oe_n, .eoi_oe_n, .panel_in, .panel_out, .remote_led, .dev_clear
);

//--- remote_local.sv
// Remote/local state machine with local lockout
`timescale 1ns/1ps
module remote_local
  import gpib_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  rl_if.ctl        rl
);

  rl_state_t state;
  rl_state_t next_state;

  // ========================================================================
  // Mode transitions
  always_comb begin
    next_state = state;
    if (!rl.ren_on) begin
      next_state = RL_LOCAL;
    end else begin
      case (state)
        RL_LOCAL: begin
          if (rl.llo_evt) begin
            next_state = RL_LOCAL_LOCK;
          end else if (rl.mla_evt) begin
            next_state = RL_REMOTE;
          end
        end
        RL_REMOTE: begin
          if (rl.gtl_evt || rl.rtl_key) begin
            next_state = RL_LOCAL;
          end else if (rl.llo_evt) begin
            next_state = RL_REMOTE_LOCK;
          end
        end
        RL_LOCAL_LOCK: begin
          if (rl.mla_evt) begin
            next_state = RL_REMOTE_LOCK;
          end
        end
        RL_REMOTE_LOCK: begin
          // Front-panel key has no effect here
          if (rl.gtl_evt) begin
            next_state = RL_LOCAL_LOCK;
          end
        end
        default: next_state = RL_LOCAL;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RL_LOCAL;
    end else begin
      state <= next_state;
    end
  end

  assign rl.remote = (state == RL_REMOTE) || (state == RL_REMOTE_LOCK);

endmodule : remote_local

//--- rl_if.sv
// Signals between the bus core and the remote/local controller
`timescale 1ns/1ps
interface rl_if;
  logic ren_on;
  logic mla_evt;
  logic gtl_evt;
  logic llo_evt;
  logic rtl_key;
  logic remote;
  modport core (output ren_on, mla_evt, gtl_evt, llo_evt, rtl_key, input remote);
  modport ctl  (input ren_on, mla_evt, gtl_evt, llo_evt, rtl_key, output remote);
endinterface : rl_if

//--- testbench.sv
// Self-checking bench: register bus master, bus controller model, result monitor
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module testbench;
  typedef struct {logic [31:0] v; logic [31:0] m; string n;} note_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, tx, seed = 32'h2715FD9D;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  dio_oe_n, c_dio, panel_in = 8'h00, panel_out, b;
  logic        dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n, srq_oe_n, hreadyout, hresp, e;
  logic        c_dav, c_nrfd, c_ndac, atn_n, ren_n, remote_led, dev_clear, rtl_key_in = 1'b0;
  logic [4:0]  adr, oth;
  note_t       q[$], nt;
  int          errors = 0, n_tests = 0, n_clr = 0;
  wire  [7:0]  w_dio = ~c_dio & dio_oe_n;
  wire         w_dav = ~c_dav & dav_oe_n, w_nrfd = ~c_nrfd & nrfd_oe_n;
  wire         w_ndac = ~c_ndac & ndac_oe_n, w_eoi = eoi_oe_n;
  always #2.5 hclk = ~hclk;
  ieee488_device_interface #(.SETTLE_CYC(2)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .dio_in(w_dio), .dio_out(), .dio_oe_n, .dav_in(w_dav),
    .dav_out(), .dav_oe_n, .nrfd_in(w_nrfd), .nrfd_out(), .nrfd_oe_n, .ndac_in(w_ndac),
    .ndac_out(), .ndac_oe_n, .eoi_in(w_eoi), .eoi_out(), .eoi_oe_n, .atn_in(atn_n),
    .ifc_in(1'b1), .ren_in(ren_n), .srq_out(), .srq_oe_n, .rtl_key_in, .panel_in, .panel_out,
    .remote_led, .dev_clear
  );
  gpib_controller_model ctl (
    .hclk, .w_dio, .w_dav, .w_nrfd, .w_ndac, .w_eoi, .c_dio, .c_dav, .c_nrfd, .c_ndac, .atn_n,
    .ren_n
  );
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, string n);
    q.push_back('{v, m, n});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic press();
    rtl_key_in <= 1'b1;
    repeat (8) @(posedge hclk);
    rtl_key_in <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : press
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================================================
  // Monitor and random panel stimulus
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      nt = q.pop_front();
      chk(nt.n, nt.v & nt.m, hrdata & nt.m);
    end
    if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    if (dev_clear === 1'b1) n_clr++;
    if (hresetn) panel_in <= 8'(xs());
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    wrap_up();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    adr = 5'(xs() % 31);
    oth = (adr == 5'd30) ? 5'd0 : adr + 5'd1;
    rd(`OFS_CTRL, 32'h1, 32'h1F, "ctrl reset");
    rd(8'h18, 32'h0, '1, "unmapped");
    bus(`OFS_CTRL, 1'b1, 32'h1F);
    rd(`OFS_CTRL, 32'h1, 32'h1F, "ctrl range");
    bus(`OFS_CTRL, 1'b1, {27'h0, adr});
    rd(`OFS_CTRL, {27'h0, adr}, 32'h1F, "ctrl addr");
    ctl.ren_n <= 1'b0;
    ctl.send({1'b0, `GRP_LISTEN, oth}, 1'b1);
    rd(`OFS_STATUS, 32'h100, 32'h10D, "other addr");
    ctl.send({1'b0, `GRP_LISTEN, adr}, 1'b1);
    ctl.send(8'h08, 1'b1);
    rd(`OFS_STATUS, 32'h109, 32'h11F, "remote listen");
    chk("led on", 32'h1, {31'h0, remote_led});
    press();
    rd(`OFS_STATUS, 32'h0, 32'h1, "key local");
    ctl.send({1'b0, `CMD_LLO}, 1'b1);
    ctl.send({1'b0, `GRP_LISTEN, adr}, 1'b1);
    press();
    rd(`OFS_STATUS, 32'h1, 32'h1, "lockout key");
    ctl.send({1'b0, `CMD_GTL}, 1'b1);
    rd(`OFS_STATUS, 32'h0, 32'h1, "go local");
    chk("led off", 32'h0, {31'h0, remote_led});
    ctl.send({1'b0, `GRP_LISTEN, adr}, 1'b1);
    ctl.ren_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(`OFS_STATUS, 32'h0, 32'h101, "ren off");
    ctl.send({1'b0, `GRP_TALK, adr}, 1'b1);
    rd(`OFS_STATUS, 32'h4, 32'hC, "talker");
    tx = xs();
    bus(`OFS_TXDATA, 1'b1, {23'h0, 1'b1, tx[7:0]});
    ctl.take(b, e);
    chk("sent byte", {23'h0, 1'b1, tx[7:0]}, {23'h0, e, b});
    rd(`OFS_STATUS, 32'h0, 32'h20, "tx done");
    ctl.send({1'b0, `GRP_LISTEN, adr}, 1'b1);
    rd(`OFS_STATUS, 32'h8, 32'hC, "untalk");
    ctl.send(tx[15:8], 1'b0);
    rd(`OFS_RXDATA, {22'h0, 2'h2, tx[15:8]}, 32'h3FF, "rx byte");
    ctl.send(8'h3F, 1'b1);
    rd(`OFS_STATUS, 32'h0, 32'h8, "unlisten");
    bus(`OFS_STB, 1'b1, 32'h41);
    rd(`OFS_STB, 32'h41, 32'hFF, "stb");
    chk("srq on", 32'h0, {31'h0, srq_oe_n});
    ctl.send({1'b0, `CMD_SPE}, 1'b1);
    ctl.send({1'b0, `GRP_TALK, adr}, 1'b1);
    ctl.slow = 20;
    ctl.take(b, e);
    chk("poll byte", 32'h41, {23'h0, e, b});
    rd(`OFS_STB, 32'h1, 32'hFF, "rsv clear");
    chk("srq off", 32'h1, {31'h0, srq_oe_n});
    ctl.send({1'b0, `CMD_SPD}, 1'b1);
    rd(`OFS_STATUS, 32'h4, 32'h14, "poll off");
    bus(`OFS_TXDATA, 1'b1, 32'h5A);
    rd(`OFS_STATUS, 32'h20, 32'h20, "tx held");
    ctl.send({1'b0, `CMD_DCL}, 1'b1);
    rd(`OFS_STATUS, 32'h0, 32'h20, "dcl flush");
    rd(`OFS_EVENT, 32'h5, 32'h7, "clear event");
    bus(`OFS_EVENT, 1'b1, 32'h1);
    rd(`OFS_EVENT, 32'h4, 32'h7, "event w1c");
    ctl.send({1'b0, `GRP_LISTEN, adr}, 1'b1);
    ctl.send(tx[23:16], 1'b0);
    ctl.send({1'b0, `CMD_SDC}, 1'b1);
    rd(`OFS_STATUS, 32'h0, 32'h40, "sdc flush");
    chk("clear pulses", 32'h2, 32'(n_clr));
    wrap_up();
  end
endmodule : testbench
